// File: shared/mfh_pkg.sv
// Constants, types and helpers for the monitor channel handler.
// Assumes a 32-bit register bus and a 32-channel monitor link.
package mfh_pkg;
	// Register byte offsets
	localparam logic [7:0] ADR_CMD  = 8'h00;
	localparam logic [7:0] ADR_STAT = 8'h04;
	localparam logic [7:0] ADR_IRQ  = 8'h08;
	localparam logic [7:0] ADR_FIFO = 8'h0C;
	localparam logic [7:0] ADR_SUB  = 8'h10;
	localparam logic [7:0] ADR_MODE = 8'h14;
	localparam logic [7:0] ADR_ACT  = 8'h18;
	localparam logic [7:0] ADR_MAP  = 8'h1C;
	// Field positions
	localparam int CMD_RST  = 0;
	localparam int CMD_SRCH = 1;
	localparam int MODE_HS  = 0;
	localparam int MODE_OPS = 1;
	localparam int IRQ_ACT  = 0;
	localparam int IRQ_DONE = 1;
	// Transfer codes and address selectors
	localparam logic [1:0] CODE_TX   = 2'h1;
	localparam logic [1:0] CODE_TXRX = 2'h2;
	localparam logic [1:0] CODE_CONT = 2'h3;
	localparam logic [1:0] SEL_BC    = 2'h1;
	localparam logic [1:0] SEL_TEST  = 2'h2;
	// Reset values
	localparam logic [7:0]  SUB_RST  = 8'h00;
	localparam logic [1:0]  MODE_RST = 2'h0;
	localparam logic [31:0] MAP_RST  = 32'h0000_0000;
	// Sizes, frame counts, receive slot offset and bus response codes
	localparam logic [4:0] FIFO_DEPTH = 5'h10;
	localparam logic [4:0] BC_LAST    = 5'h02;
	localparam logic [5:0] LINE_OFS   = 6'h04;
	localparam logic [1:0] RESP_OK    = 2'h0;
	localparam logic [1:0] RESP_ERR   = 2'h2;

	typedef enum logic [2:0] {s_idle, s_tx, s_hold, s_rx, s_full} mfh_state_t;

	// Frames in a non-handshake receive phase
	function automatic logic [4:0] rx_frames(input logic [1:0] sel);
		case (sel)
			2'h0: rx_frames = 5'h01;
			2'h1: rx_frames = 5'h02;
			2'h2: rx_frames = 5'h08;
			default: rx_frames = 5'h10;
		endcase
	endfunction : rx_frames

	// Lowest channel with an active handshake
	function automatic logic [5:0] first_set(input logic [31:0] m);
		first_set = 6'h00;
		for (int k = 31; k >= 0; k--) begin
			if (m[k]) begin
				first_set = 6'(k);
			end
		end
	endfunction : first_set
endpackage : mfh_pkg

// File: design/mfh_core.sv
// Monitor channel command handler: FIFO, transfer engine, search, AXI4-Lite slave.
// Assumes link pins are asynchronous and a frame marker rises once per frame.
`timescale 1ns/1ps
module mfh_core (
	input  wire logic        i_mclk,
	input  wire logic        i_rst_b,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	input  wire logic        i_frame,
	input  wire logic [7:0]  i_rx_data,
	input  wire logic        i_rx_hs,
	input  wire logic        i_rx_ack,
	input  wire logic        i_rx_abort,
	input  wire logic [31:0] i_act_map,
	output logic [7:0]       o_tx_data,
	output logic [31:0]      o_tx_map,
	output logic             o_tx_hs,
	output logic [5:0]       o_rx_slot,
	output logic             o_rx_ack
);
	mfh_pkg::mfh_state_t st_q, st_d;
	logic [43:0] sy1_q, sy2_q;
	logic        fr_q, fr, lhs, lack, lab;
	logic [7:0]  ld;
	logic [31:0] lmap;
	logic [7:0]  mem [16];
	logic [3:0]  wp_q, wp_d, rp_q, rp_d;
	logic [4:0]  cnt_q, cnt_d, fc_q, fc_d;
	logic        push, pop, frst, wr, rd, cmd_wr, ae, emp, full;
	logic [7:0]  pdat, stat;
	logic        dir_q, dir_d, ab_q, ab_d, w_q, w_d, q_q, q_d;
	logic        cont_q, cont_d, rxa_q, rxa_d, bc_q, bc_d;
	logic        srch_q, srch_d;
	logic [7:0]  sub_q, sub_d;
	logic [1:0]  mode_q, mode_d, irq_q, irq_d;
	logic [5:0]  act_q, act_d, rsl_q, rsl_d;
	logic [31:0] map_q, map_d, txm_q, txm_d;
	logic [7:0]  txd_q, txd_d;
	logic        txh_q, txh_d, rak_q, rak_d;
	logic        awr_q, awr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
	logic [1:0]  br_q, br_d, rr_q, rr_d;
	logic [31:0] rdt_q, rdt_d;
	// Local names for the package state literals
	localparam mfh_pkg::mfh_state_t s_idle = mfh_pkg::s_idle;
	localparam mfh_pkg::mfh_state_t s_tx   = mfh_pkg::s_tx;
	localparam mfh_pkg::mfh_state_t s_hold = mfh_pkg::s_hold;
	localparam mfh_pkg::mfh_state_t s_rx   = mfh_pkg::s_rx;
	localparam mfh_pkg::mfh_state_t s_full = mfh_pkg::s_full;

	// Synchronised link pins
	assign {ld, lhs, lack, lab, lmap} = sy2_q[42:0];
	assign fr = sy2_q[43] & ~fr_q;
	// Live status view
	assign emp  = (cnt_q == 5'h00);
	assign full = (cnt_q == mfh_pkg::FIFO_DEPTH);
	assign ae   = (st_q == s_idle) || (st_q == s_hold) || (st_q == s_full);
	assign stat = {3'h0, st_q != s_idle, ab_q, ae, dir_q, emp};

	// Next-state logic for bus, FIFO, transfer engine and search
	always_comb begin
		st_d = st_q; dir_d = dir_q; ab_d = ab_q; w_d = w_q; q_d = q_q;
		cont_d = cont_q; rxa_d = rxa_q; bc_d = bc_q; fc_d = fc_q;
		srch_d = srch_q; sub_d = sub_q; mode_d = mode_q; irq_d = irq_q;
		act_d = act_q; map_d = map_q; txm_d = txm_q; txd_d = txd_q;
		txh_d = txh_q; rak_d = rak_q; rsl_d = rsl_q;
		br_d = br_q; rr_d = rr_q; rdt_d = rdt_q;
		push = 1'b0;
		pop = 1'b0;
		frst = 1'b0;
		pdat = ld;
		// Bus handshakes: one write and one read in flight
		wr = awr_q & i_awvalid & i_wvalid;
		rd = arr_q & i_arvalid;
		cmd_wr = wr && (i_awaddr == mfh_pkg::ADR_CMD) && i_wstrb[0];
		awr_d = ~awr_q & i_awvalid & i_wvalid & ~bv_q;
		arr_d = ~arr_q & i_arvalid & ~rv_q;
		bv_d = wr | (bv_q & ~i_bready);
		rv_d = rd | (rv_q & ~i_rready);
		// Read data and read side effects
		if (rd) begin
			rr_d = mfh_pkg::RESP_OK;
			rdt_d = 32'h0000_0000;
			case (i_araddr)
				mfh_pkg::ADR_STAT: rdt_d[7:0] = stat;
				mfh_pkg::ADR_IRQ: begin
					rdt_d[1:0] = irq_q;
					irq_d = 2'h0;
				end
				mfh_pkg::ADR_FIFO: begin
					rdt_d[7:0] = mem[rp_q];
					pop = ae & dir_q & ~emp;
				end
				mfh_pkg::ADR_SUB:  rdt_d[7:0] = sub_q;
				mfh_pkg::ADR_MODE: rdt_d[1:0] = mode_q;
				mfh_pkg::ADR_ACT:  rdt_d[5:0] = act_q;
				mfh_pkg::ADR_MAP:  rdt_d = map_q;
				mfh_pkg::ADR_CMD: ;
				default: rr_d = mfh_pkg::RESP_ERR;
			endcase
		end
		// Per-frame transfer engine
		if (fr) begin
			rak_d = 1'b0;
			case (st_q)
				s_tx: begin
					if (emp && !w_q) begin
						if (cont_q) begin
							st_d = s_hold;
							txh_d = 1'b1;
							irq_d[mfh_pkg::IRQ_DONE] = 1'b1;
						end else if (rxa_q) begin
							st_d = s_rx;
							txh_d = 1'b0;
							txm_d = '0;
							fc_d = 5'h00;
							q_d = 1'b0;
						end else begin
							st_d = s_idle;
							txh_d = 1'b0;
							txm_d = '0;
							irq_d[mfh_pkg::IRQ_DONE] = 1'b1;
						end
					end else if (!mode_q[mfh_pkg::MODE_HS]) begin
						pop = 1'b1;
						txd_d = mem[rp_q];
						txm_d = bc_q ? map_q : (32'h0000_0001 << sub_q[4:0]);
					end else if (bc_q) begin
						fc_d = (fc_q == mfh_pkg::BC_LAST) ? 5'h00 : 5'(fc_q + 5'h01);
						if (fc_q == 5'h00) begin
							pop = 1'b1;
							txd_d = mem[rp_q];
							txh_d = 1'b1;
							txm_d = map_q;
						end
					end else if (lab) begin
						st_d = s_idle;
						ab_d = 1'b1;
						txh_d = 1'b0;
						txm_d = '0;
						irq_d[mfh_pkg::IRQ_DONE] = 1'b1;
					end else if (!w_q) begin
						pop = 1'b1;
						txd_d = mem[rp_q];
						txh_d = 1'b1;
						txm_d = 32'h0000_0001 << sub_q[4:0];
						w_d = 1'b1;
					end else if (lack) begin
						w_d = 1'b0;
					end
				end
				s_rx: begin
					if (mode_q[mfh_pkg::MODE_HS]) begin
						if (lhs) begin
							q_d = 1'b0;
							if (full) begin
								st_d = s_full;
								irq_d[mfh_pkg::IRQ_DONE] = 1'b1;
							end else begin
								push = 1'b1;
								rak_d = 1'b1;
							end
						end else if (q_q) begin
							st_d = s_idle;
							irq_d[mfh_pkg::IRQ_DONE] = 1'b1;
						end else begin
							q_d = 1'b1;
						end
					end else begin
						push = ~full;
						fc_d = 5'(fc_q + 5'h01);
						if (5'(fc_q + 5'h01) == mfh_pkg::rx_frames(sub_q[7:6])) begin
							st_d = s_idle;
							irq_d[mfh_pkg::IRQ_DONE] = 1'b1;
						end
					end
				end
				default: ;
			endcase
			// Search for a remote transmitter
			if (srch_q && (lmap != 32'h0000_0000)) begin
				srch_d = 1'b0;
				act_d = mfh_pkg::first_set(lmap);
				irq_d[mfh_pkg::IRQ_ACT] = 1'b1;
			end
		end
		// Register writes and commands
		if (wr) begin
			br_d = mfh_pkg::RESP_OK;
			case (i_awaddr)
				mfh_pkg::ADR_SUB:  sub_d = i_wdata[7:0];
				mfh_pkg::ADR_MODE: mode_d = i_wdata[1:0];
				mfh_pkg::ADR_MAP:  map_d = i_wdata;
				mfh_pkg::ADR_FIFO: begin
					push = i_wstrb[0] & ae & ~dir_q & ~full;
					pdat = i_wdata[7:0];
				end
				mfh_pkg::ADR_CMD, mfh_pkg::ADR_STAT,
				mfh_pkg::ADR_IRQ, mfh_pkg::ADR_ACT: ;
				default: br_d = mfh_pkg::RESP_ERR;
			endcase
		end
		if (cmd_wr && i_wdata[mfh_pkg::CMD_RST]) begin
			frst = 1'b1;
			st_d = s_idle;
			dir_d = 1'b0; ab_d = 1'b0; w_d = 1'b0;
			cont_d = 1'b0; rxa_d = 1'b0; bc_d = 1'b0;
			txh_d = 1'b0; rak_d = 1'b0; txm_d = '0;
		end else if (cmd_wr) begin
			if (i_wdata[mfh_pkg::CMD_SRCH] && mode_q[mfh_pkg::MODE_HS]) begin
				srch_d = 1'b1;
			end
			if (ae && (i_wdata[3:2] != 2'h0)) begin
				w_d = 1'b0; q_d = 1'b0; fc_d = 5'h00; dir_d = 1'b0;
				cont_d = 1'b0; rxa_d = 1'b0; bc_d = 1'b0;
				rsl_d = sub_q[5:0];
				st_d = s_tx;
				case (i_wdata[3:2])
					mfh_pkg::CODE_TX: begin
						if (sub_q[7:6] == mfh_pkg::SEL_TEST) begin
							st_d = s_idle;
							dir_d = 1'b1;
							irq_d[mfh_pkg::IRQ_DONE] = 1'b1;
						end
						bc_d = (sub_q[7:6] == mfh_pkg::SEL_BC);
					end
					mfh_pkg::CODE_TXRX: rxa_d = 1'b1;
					default: begin
						cont_d = mode_q[mfh_pkg::MODE_HS];
						rxa_d = ~mode_q[mfh_pkg::MODE_HS];
						if (!mode_q[mfh_pkg::MODE_HS]) begin
							rsl_d = 6'(sub_q[5:0] + mfh_pkg::LINE_OFS);
						end
					end
				endcase
			end
		end
		if (st_d == s_rx && st_q != s_rx) begin
			dir_d = 1'b1;
		end
		if (!mode_q[mfh_pkg::MODE_OPS]) begin
			srch_d = 1'b0;
		end
		// FIFO pointers; reset leaves it empty and writable
		if (frst) begin
			wp_d = 4'h0; rp_d = 4'h0; cnt_d = 5'h00;
		end else begin
			wp_d = 4'(wp_q + {3'h0, push});
			rp_d = 4'(rp_q + {3'h0, pop});
			cnt_d = 5'(cnt_q + {4'h0, push} - {4'h0, pop});
		end
	end

	// Registers
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sy1_q <= '0; sy2_q <= '0; fr_q <= 1'b0;
			st_q <= s_idle; dir_q <= 1'b0; ab_q <= 1'b0; w_q <= 1'b0;
			q_q <= 1'b0; cont_q <= 1'b0; rxa_q <= 1'b0; bc_q <= 1'b0;
			fc_q <= 5'h00; srch_q <= 1'b0; sub_q <= mfh_pkg::SUB_RST;
			mode_q <= mfh_pkg::MODE_RST; irq_q <= 2'h0; act_q <= 6'h00;
			map_q <= mfh_pkg::MAP_RST; txm_q <= '0; txd_q <= 8'h00;
			txh_q <= 1'b0; rak_q <= 1'b0; rsl_q <= 6'h00;
			wp_q <= 4'h0; rp_q <= 4'h0; cnt_q <= 5'h00;
			awr_q <= 1'b0; bv_q <= 1'b0; arr_q <= 1'b0; rv_q <= 1'b0;
			br_q <= 2'h0; rr_q <= 2'h0; rdt_q <= 32'h0000_0000;
		end else begin
			sy1_q <= {i_frame, i_rx_data, i_rx_hs, i_rx_ack, i_rx_abort, i_act_map};
			sy2_q <= sy1_q;
			fr_q <= sy2_q[43];
			st_q <= st_d; dir_q <= dir_d; ab_q <= ab_d; w_q <= w_d;
			q_q <= q_d; cont_q <= cont_d; rxa_q <= rxa_d; bc_q <= bc_d;
			fc_q <= fc_d; srch_q <= srch_d; sub_q <= sub_d;
			mode_q <= mode_d; irq_q <= irq_d; act_q <= act_d;
			map_q <= map_d; txm_q <= txm_d; txd_q <= txd_d;
			txh_q <= txh_d; rak_q <= rak_d; rsl_q <= rsl_d;
			wp_q <= wp_d; rp_q <= rp_d; cnt_q <= cnt_d;
			awr_q <= awr_d; bv_q <= bv_d; arr_q <= arr_d; rv_q <= rv_d;
			br_q <= br_d; rr_q <= rr_d; rdt_q <= rdt_d;
		end
	end

	// Message storage
	always_ff @(posedge i_mclk) begin
		if (push && !frst) begin
			mem[wp_q] <= pdat;
		end
	end

	// Outputs straight from flops
	assign o_awready = awr_q;
	assign o_wready  = awr_q;
	assign o_bvalid  = bv_q;
	assign o_bresp   = br_q;
	assign o_arready = arr_q;
	assign o_rvalid  = rv_q;
	assign o_rresp   = rr_q;
	assign o_rdata   = rdt_q;
	assign o_tx_data = txd_q;
	assign o_tx_map  = txm_q;
	assign o_tx_hs   = txh_q;
	assign o_rx_slot = rsl_q;
	assign o_rx_ack  = rak_q;

	// Checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	sequence s_rst_cmd;
		cmd_wr && i_wdata[mfh_pkg::CMD_RST];
	endsequence
	sequence s_quiet2;
		fr && st_q == s_rx && mode_q[mfh_pkg::MODE_HS] && !lhs && q_q;
	endsequence
	sequence s_hit;
		fr && srch_q && lmap != 32'h0000_0000 && mode_q[mfh_pkg::MODE_OPS];
	endsequence

	AST_FIFO_RST:
	assert property (s_rst_cmd |=> cnt_q == 5'h00 && !dir_q && st_q == s_idle)
		else $error("fifo reset did not empty and idle");
	AST_RX_ABORT:
	assert property (st_q == s_rx ##0 s_rst_cmd |=> st_q == s_idle && !o_rx_ack)
		else $error("reception not aborted by fifo reset");
	AST_RX_END:
	assert property (s_quiet2 |=> st_q == s_idle && irq_q[mfh_pkg::IRQ_DONE])
		else $error("two quiet frames did not end reception");
	AST_HOLD_HS:
	assert property (st_q == s_hold |-> o_tx_hs && !dir_q)
		else $error("continuous hold lost handshake");
	AST_FULL:
	assert property (st_q == s_full |-> !o_rx_ack && dir_q && stat[4])
		else $error("full state wrong");
	AST_CAP:
	assert property (cnt_q <= mfh_pkg::FIFO_DEPTH)
		else $error("fifo over capacity");
	AST_SRCH_OFF:
	assert property (!mode_q[mfh_pkg::MODE_OPS] |=> !srch_q)
		else $error("search survived operate clear");
	AST_SRCH_HIT:
	assert property (s_hit |=> !srch_q && irq_q[mfh_pkg::IRQ_ACT]
		&& act_q == mfh_pkg::first_set($past(lmap)))
		else $error("search hit not recorded");
	AST_TEST:
	assert property (cmd_wr && !i_wdata[mfh_pkg::CMD_RST] && i_wdata[3:2] == mfh_pkg::CODE_TX
		&& sub_q[7:6] == mfh_pkg::SEL_TEST && ae |=> dir_q && st_q == s_idle
		&& irq_q[mfh_pkg::IRQ_DONE]) else $error("test loopback status wrong");
endmodule : mfh_core

// File: bench/mfh_link_model.sv
// Subscriber side of the monitor link: frame pin, handshaked messages, acknowledges.
// Assumes the bench sets length and base before pulsing i_go.
`timescale 1ns/1ps
module mfh_link_model (
	input  wire logic       i_mclk,
	input  wire logic       i_rst_b,
	input  wire logic       i_go,
	input  wire logic       i_slow,
	input  wire logic [5:0] i_len,
	input  wire logic [7:0] i_base,
	input  wire logic       i_dev_hs,
	input  wire logic       i_dev_ack,
	output logic            o_frame,
	output logic [7:0]      o_data,
	output logic            o_hs,
	output logic            o_ack
);
	logic [3:0] cyc_q;
	logic [5:0] idx_q;
	logic       shown_q, seen_q, odd_q;

	// Frame pin high for the first half of a 16-cycle frame
	assign o_frame = ~cyc_q[3];

	// Bytes shown every other frame; resend until acknowledged
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cyc_q <= '0;
			idx_q <= '0;
			shown_q <= 1'b0;
			seen_q <= 1'b0;
			odd_q <= 1'b0;
			o_data <= '0;
			o_hs <= 1'b0;
			o_ack <= 1'b0;
		end else begin
			cyc_q <= cyc_q + 4'h1;
			if (i_dev_ack) begin
				seen_q <= 1'b1;
			end
			if (cyc_q == 4'hf) begin
				seen_q <= 1'b0;
				odd_q <= !odd_q;
				o_ack <= i_dev_hs && (!i_slow || odd_q);
				if (idx_q != i_len && !shown_q) begin
					o_hs <= 1'b1;
					o_data <= i_base + 8'(idx_q);
					shown_q <= 1'b1;
				end else begin
					o_hs <= 1'b0;
					o_data <= ~o_data;
					shown_q <= 1'b0;
					if (shown_q && (seen_q || i_dev_ack)) begin
						idx_q <= idx_q + 6'h01;
					end
				end
			end
			if (i_go) begin
				idx_q <= '0;
				shown_q <= 1'b0;
			end
		end
	end
endmodule : mfh_link_model

// File: bench/tb_top.sv
// Self-checking bench for the monitor channel handler over its register bus.
// Assumes the link model paces messages by the handler's acknowledges.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; \
	$display("ERROR %s exp %h got %h", n, e, s); end end
module tb_top;
	logic        i_mclk, i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic [7:0]  i_awaddr, i_araddr, rx_data, base;
	logic [31:0] i_wdata, i_act_map, o_rdata, o_tx_map, v, m;
	logic [3:0]  i_wstrb;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_tx_hs, o_rx_ack;
	logic [1:0]  o_bresp, o_rresp, r;
	logic [7:0]  o_tx_data;
	logic [5:0]  o_rx_slot, len;
	logic        frame, rx_hs, rx_ack, go, slow;
	logic [7:0]  exp_q[$];
	int          error_cnt, checks, cyc, n, k;

	mfh_core DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_awaddr(i_awaddr),
		.i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
		.i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
		.i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
		.o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
		.i_rready(i_rready), .i_frame(frame), .i_rx_data(rx_data), .i_rx_hs(rx_hs),
		.i_rx_ack(rx_ack), .i_rx_abort(1'b0), .i_act_map(i_act_map), .o_tx_data(o_tx_data),
		.o_tx_map(o_tx_map), .o_tx_hs(o_tx_hs), .o_rx_slot(o_rx_slot), .o_rx_ack(o_rx_ack));

	mfh_link_model PEER (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_go(go), .i_slow(slow),
		.i_len(len), .i_base(base), .i_dev_hs(o_tx_hs), .i_dev_ack(o_rx_ack),
		.o_frame(frame), .o_data(rx_data), .o_hs(rx_hs), .o_ack(rx_ack));

	// Clock and hang guard
	always #25 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			final_report();
		end
	end

	task automatic final_report;
		if (error_cnt == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : final_report

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do @(posedge i_mclk); while (!o_awready);
		i_awvalid <= 1'b0;
		i_wvalid <= 1'b0;
		do @(posedge i_mclk); while (!o_bvalid);
		r = o_bresp;
		i_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge i_mclk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do @(posedge i_mclk); while (!o_arready);
		i_arvalid <= 1'b0;
		do @(posedge i_mclk); while (!o_rvalid);
		v = o_rdata;
		r = o_rresp;
		i_rready <= 1'b0;
	endtask : rd

	// Read bytes while the empty flag is clear, comparing with the queue
	task automatic drain(output int cnt);
		cnt = 0;
		forever begin
			rd(mfh_pkg::ADR_STAT);
			if (v[0]) break;
			rd(mfh_pkg::ADR_FIFO);
			if (exp_q.size() > 0) `CHK("fifo byte", exp_q.pop_front(), v[7:0])
			cnt++;
		end
	endtask : drain

	task automatic wait_irq(input int b);
		do rd(mfh_pkg::ADR_IRQ); while (!v[b]);
	endtask : wait_irq

	task automatic msg(input int l);
		len <= 6'(l);
		base <= 8'($urandom);
		go <= 1'b1;
		@(posedge i_mclk);
		go <= 1'b0;
		@(posedge i_mclk);
		for (int i = 0; i < l; i++) exp_q.push_back(base + 8'(i));
	endtask : msg

	function automatic int frames(input int s);
		return (s == 0) ? 1 : (s == 1) ? 2 : (s == 2) ? 8 : 16;
	endfunction : frames

	function automatic logic [31:0] low_bit(input logic [31:0] mp);
		low_bit = '0;
		for (int i = 31; i >= 0; i--) if (mp[i]) low_bit = i;
	endfunction : low_bit

	// Main sequence
	initial begin
		{i_mclk, i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
		{i_awaddr, i_araddr, i_wdata, i_act_map, go, slow, len, base} = '0;
		i_wstrb = 4'hf;
		void'($urandom(45));
		repeat (10) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		rd(mfh_pkg::ADR_STAT);
		`CHK("stat reset", 32'h0000_0005, v)
		rd(8'h20);
		`CHK("unmapped", mfh_pkg::RESP_ERR, r)
		// Handshaked receive only, random length
		wr(mfh_pkg::ADR_MODE, 32'h0000_0003);
		wr(mfh_pkg::ADR_SUB, 32'h0000_0005);
		wr(mfh_pkg::ADR_CMD, 32'h0000_0008);
		n = 1 + $urandom_range(15);
		msg(n);
		wait_irq(mfh_pkg::IRQ_DONE);
		rd(mfh_pkg::ADR_STAT);
		`CHK("stat done", 32'h0000_0006, v)
		drain(k);
		`CHK("rx count", n, k)
		wr(mfh_pkg::ADR_CMD, 32'h0000_0001);
		rd(mfh_pkg::ADR_STAT);
		`CHK("stat reset cmd", 32'h0000_0005, v)
		// Overlong message: full, drain, resume
		slow <= 1'b1;
		wr(mfh_pkg::ADR_CMD, 32'h0000_0008);
		msg(20);
		wait_irq(mfh_pkg::IRQ_DONE);
		rd(mfh_pkg::ADR_STAT);
		`CHK("stat full", 32'h0000_0016, v)
		drain(k);
		`CHK("stored max", 16, k)
		`CHK("stat drained", 32'h0000_0017, v)
		wr(mfh_pkg::ADR_CMD, 32'h0000_0008);
		wait_irq(mfh_pkg::IRQ_DONE);
		drain(k);
		`CHK("resumed count", 4, k)
		wr(mfh_pkg::ADR_CMD, 32'h0000_0001);
		// Reset during reception aborts it
		wr(mfh_pkg::ADR_CMD, 32'h0000_0008);
		msg(20);
		repeat (200) @(posedge i_mclk);
		wr(mfh_pkg::ADR_CMD, 32'h0000_0001);
		rd(mfh_pkg::ADR_STAT);
		`CHK("stat abort", 32'h0000_0005, v)
		msg(0);
		exp_q.delete();
		// Search for an active channel
		m = $urandom | 32'h8000_0000;
		i_act_map <= m;
		wr(mfh_pkg::ADR_CMD, 32'h0000_0002);
		wait_irq(mfh_pkg::IRQ_ACT);
		rd(mfh_pkg::ADR_ACT);
		`CHK("found chan", low_bit(m), v)
		i_act_map <= '0;
		// Test loopback
		for (int i = 0; i < 3; i++) begin
			exp_q.push_back(8'($urandom));
			wr(mfh_pkg::ADR_FIFO, {24'h0, exp_q[i]});
		end
		wr(mfh_pkg::ADR_SUB, 32'h0000_0080);
		wr(mfh_pkg::ADR_CMD, 32'h0000_0004);
		wait_irq(mfh_pkg::IRQ_DONE);
		drain(k);
		`CHK("loop count", 3, k)
		wr(mfh_pkg::ADR_CMD, 32'h0000_0001);
		// Continuous transmit: two-byte block, then a one-byte closing block
		wr(mfh_pkg::ADR_FIFO, {24'h0, 8'($urandom)});
		wr(mfh_pkg::ADR_FIFO, {24'h0, 8'($urandom)});
		wr(mfh_pkg::ADR_SUB, 32'h0000_0005);
		wr(mfh_pkg::ADR_CMD, 32'h0000_000C);
		wait_irq(mfh_pkg::IRQ_DONE);
		rd(mfh_pkg::ADR_STAT);
		`CHK("stat hold", 32'h0000_0015, v)
		`CHK("hold hs", 1'b1, o_tx_hs)
		`CHK("tx map", 32'h0000_0020, o_tx_map)
		base = 8'($urandom);
		wr(mfh_pkg::ADR_FIFO, {24'h0, base});
		wr(mfh_pkg::ADR_CMD, 32'h0000_0004);
		wait_irq(mfh_pkg::IRQ_DONE);
		rd(mfh_pkg::ADR_STAT);
		`CHK("stat end", 32'h0000_0005, v)
		`CHK("end hs", 1'b0, o_tx_hs)
		`CHK("last byte", base, o_tx_data)
		wr(mfh_pkg::ADR_CMD, 32'h0000_0001);
		// Non-handshaked receive counts
		wr(mfh_pkg::ADR_MODE, 32'h0000_0002);
		for (int s = 0; s < 4; s++) begin
			wr(mfh_pkg::ADR_SUB, 32'(s << 6) | 32'h0000_0005);
			wr(mfh_pkg::ADR_CMD, (s == 3) ? 32'h0000_000C : 32'h0000_0008);
			`CHK("rx slot", (s == 3) ? 6'h09 : 6'h05, o_rx_slot)
			wait_irq(mfh_pkg::IRQ_DONE);
			drain(k);
			`CHK("frame count", frames(s), k)
			wr(mfh_pkg::ADR_CMD, 32'h0000_0001);
		end
		final_report();
	end
endmodule : tb_top
